// [hw/flash_ctrl_map.vh]
// Register map, field positions and reset values of the flash controller register interface.
// Overview of operation
// - Program width bit selects 32 or 64 bits.
// - Data cache flush only while data cache off.
// - Instr cache flush only while instr cache off.
// - Enable bits switch each cache on or off.
// - Wait codes 0 to 3 add waits; rest reserved.
// - Done flag set on successful erase or program.
// - Protect error set on protected page operation.
// - Align error set on misaligned programming write.
// - Program error set when target not erased.
// - Flags stay set until software writes one.
// - Busy reads one during operation, clears after.
// - Control register resets to 0x80, locked.
// - Wait and cache register resets to 0x630.
// - Correct key clears lock; software may relock.
// - Option key sets option enable while control unlocked; software clears.
// - Done interrupt when enabled and done flag set.
// - Error interrupt when enabled and error flag set.
`ifndef FLASH_CTRL_MAP_VH
`define FLASH_CTRL_MAP_VH
`define OFS_WAIT_CACHE_CONFIG   5'h00
`define OFS_CONTROL_UNLOCK_KEY  5'h04
`define OFS_OPTION_UNLOCK_KEY   5'h08
`define OFS_OPERATION_STATUS    5'h0c
`define OFS_OPERATION_CONTROL   5'h10
`define RST_WAIT_CACHE_CONFIG   32'h00000630
`define RST_OPERATION_CONTROL   32'h00000080
`define WS_MASK                 32'h00009e37
`define WS_PGW                  15
`define WS_DATA_CACHE_FLUSH                12
`define WS_INSTR_CACHE_FLUSH                11
`define WS_DATA_CACHE_ON                 10
`define WS_INSTR_CACHE_ON                 9
`define WS_PREFETCH_ON                 4
`define ST_OP_DONE_FLAG                 5
`define ST_PROTECT_ERROR_FLAG                4
`define ST_ALIGN_ERROR_FLAG               3
`define ST_PROGRAM_ERROR_FLAG                2
`define ST_BUSY                 0
`define CT_DONE_IRQ_ENABLE                12
`define CT_ERROR_IRQ_ENABLE                10
`define CT_OPTION_WRITE_ALLOWED                9
`define CT_LK                   7
`define CT_SW_MASK              32'h000014ff
`define KEY_WORD1               32'h45670123
`define KEY_WORD2               32'hcdef89ab
`endif

// [hw/flash_read_wait.v]
// Wait-state delay for flash read accesses.
`timescale 1ns/100ps
module flash_read_wait (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [2:0]  wait_state_count,
  input  wire        rd_req,
  input  wire [31:0] rd_data_in,
  output reg         rd_ack,
  output reg  [31:0] rd_data
);
  reg       busy_r;
  reg [1:0] cnt_r;
  // Reserved codes are clipped to three waits so a bad setting cannot hang the port.
  wire [1:0] waits = wait_state_count[2] ? 2'h3 : wait_state_count[1:0];
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy_r  <= 1'b0;
      cnt_r   <= 2'h0;
      rd_ack  <= 1'b0;
      rd_data <= 32'h00000000;
    end
    else
    begin
      rd_ack <= 1'b0;
      if (!busy_r && rd_req)
      begin
        if (waits == 2'h0)
        begin
          rd_ack  <= 1'b1;
          rd_data <= rd_data_in;
        end
        else
        begin
          busy_r <= 1'b1;
          cnt_r  <= waits;
        end
      end
      else if (busy_r)
      begin
        if (cnt_r == 2'h1)
        begin
          busy_r  <= 1'b0;
          rd_ack  <= 1'b1;
          rd_data <= rd_data_in;
        end
        cnt_r <= cnt_r - 2'h1;
      end
    end
  end
endmodule

// [hw/flash_ctrl_register_interface.v]
// AXI4-Lite register interface of the flash controller with status flags and read wait states.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "flash_ctrl_map.vh"
module flash_ctrl_register_interface (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        op_start,
  input  wire        op_done,
  input  wire        op_protect_err,
  input  wire        op_align_err,
  input  wire        op_program_err,
  input  wire        flash_rd_req,
  input  wire [31:0] flash_rd_data_in,
  output wire        flash_rd_ack,
  output wire [31:0] flash_rd_data,
  output wire [2:0]  wait_state_count,
  output wire        prefetch_on,
  output wire        instr_cache_on,
  output wire        data_cache_on,
  output reg         instr_cache_flush,
  output reg         data_cache_flush,
  output wire        program_width_sel,
  output wire [6:0]  control_cmd,
  output wire        control_locked,
  output wire        option_write_allowed,
  output wire        done_irq,
  output wire        error_irq
);
  reg  [31:0] ws_r;
  reg  [31:0] ctl_r;
  reg  [5:0]  stat_r;
  reg  [5:0]  stat_nxt;
  reg         key_stage_r;
  reg         option_unlock_word_stage_r;
  reg         aw_held_r;
  reg  [4:0]  aw_addr_r;
  reg         w_held_r;
  reg  [31:0] w_data_r;
  reg  [3:0]  w_strb_r;

  function addr_ok;
    input [31:0] a;
    begin
      addr_ok = (a[31:5] == 27'h0) && (a[1:0] == 2'h0) && (a[4:2] <= 3'h4);
    end
  endfunction

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        aw_fire = s_axi_awvalid && s_axi_awready;
  wire        w_fire  = s_axi_wvalid && s_axi_wready;
  wire        aw_have = aw_held_r || aw_fire;
  wire        w_have  = w_held_r || w_fire;
  wire [4:0]  wa      = aw_held_r ? aw_addr_r : s_axi_awaddr[4:0];
  wire [31:0] wd      = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0]  ws      = w_held_r ? w_strb_r : s_axi_wstrb;
  wire        wr_go   = aw_have && w_have;
  // Narrow writes are answered with an error and change nothing.
  wire        full_w  = (ws == 4'hf);
  reg         aw_pend_addr_ok_r;
  // Held address is kept at five bits; upper address bits are checked when taken.
  wire        wr_addr_bad = aw_held_r ? !aw_pend_addr_ok_r : !addr_ok(s_axi_awaddr);
  wire        wr_ok   = wr_go && full_w && !wr_addr_bad;
  wire        wr_ws   = wr_ok && (wa == `OFS_WAIT_CACHE_CONFIG);
  wire        wr_key  = wr_ok && (wa == `OFS_CONTROL_UNLOCK_KEY);
  wire        wr_ob   = wr_ok && (wa == `OFS_OPTION_UNLOCK_KEY);
  wire        wr_st   = wr_ok && (wa == `OFS_OPERATION_STATUS);
  wire        wr_ct   = wr_ok && (wa == `OFS_OPERATION_CONTROL);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r    <= 1'b0;
      aw_addr_r    <= 5'h00;
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h00000000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      aw_pend_addr_ok_r <= 1'b0;
    end
    else
    begin
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end
      else
      begin
        if (aw_fire)
        begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr[4:0];
          aw_pend_addr_ok_r <= addr_ok(s_axi_awaddr);
        end
        if (w_fire)
        begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ws_r              <= `RST_WAIT_CACHE_CONFIG;
      instr_cache_flush <= 1'b0;
      data_cache_flush  <= 1'b0;
    end
    else
    begin
      instr_cache_flush <= 1'b0;
      data_cache_flush  <= 1'b0;
      if (wr_ws && !wr_addr_bad)
      begin
        ws_r[`WS_PGW]  <= wd[`WS_PGW];
        ws_r[`WS_DATA_CACHE_ON] <= wd[`WS_DATA_CACHE_ON];
        ws_r[`WS_INSTR_CACHE_ON] <= wd[`WS_INSTR_CACHE_ON];
        ws_r[`WS_PREFETCH_ON] <= wd[`WS_PREFETCH_ON];
        ws_r[2:0]      <= wd[2:0];
        // Flush bits are accepted only while their cache is off and self-clear after a pulse.
        if (!ws_r[`WS_DATA_CACHE_ON])
          data_cache_flush <= wd[`WS_DATA_CACHE_FLUSH];
        if (!ws_r[`WS_INSTR_CACHE_ON])
          instr_cache_flush <= wd[`WS_INSTR_CACHE_FLUSH];
      end
    end
  end

  assign program_width_sel = ws_r[`WS_PGW];
  assign data_cache_on     = ws_r[`WS_DATA_CACHE_ON];
  assign instr_cache_on    = ws_r[`WS_INSTR_CACHE_ON];
  assign prefetch_on       = ws_r[`WS_PREFETCH_ON];
  assign wait_state_count  = ws_r[2:0];

  // Hardware events win over a clearing write in the same cycle.
  always @*
  begin
    stat_nxt = stat_r;
    if (wr_st && !wr_addr_bad)
      stat_nxt[5:2] = stat_r[5:2] & ~wd[5:2];
    if (op_start)
      stat_nxt[`ST_BUSY] = 1'b1;
    if (op_done || op_protect_err || op_align_err || op_program_err)
      stat_nxt[`ST_BUSY] = 1'b0;
    if (op_done && !(op_protect_err || op_align_err || op_program_err))
      stat_nxt[`ST_OP_DONE_FLAG] = 1'b1;
    if (op_protect_err)
      stat_nxt[`ST_PROTECT_ERROR_FLAG] = 1'b1;
    if (op_align_err)
      stat_nxt[`ST_ALIGN_ERROR_FLAG] = 1'b1;
    if (op_program_err)
      stat_nxt[`ST_PROGRAM_ERROR_FLAG] = 1'b1;
    stat_nxt[1] = 1'b0;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      stat_r <= 6'h00;
    else
      stat_r <= stat_nxt;
  end

  // A key write of any other value, or out of order, restarts the sequence.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_r         <= `RST_OPERATION_CONTROL;
      key_stage_r   <= 1'b0;
      option_unlock_word_stage_r <= 1'b0;
    end
    else
    begin
      if (wr_key && !wr_addr_bad)
      begin
        if (key_stage_r && (wd == `KEY_WORD2))
        begin
          ctl_r[`CT_LK] <= 1'b0;
          key_stage_r   <= 1'b0;
        end
        else
          key_stage_r <= (wd == `KEY_WORD1);
      end
      else if (wr_ob && !wr_addr_bad)
      begin
        if (option_unlock_word_stage_r && (wd == `KEY_WORD2) && !ctl_r[`CT_LK])
        begin
          ctl_r[`CT_OPTION_WRITE_ALLOWED] <= 1'b1;
          option_unlock_word_stage_r    <= 1'b0;
        end
        else
          option_unlock_word_stage_r <= (wd == `KEY_WORD1);
      end
      else if (wr_ct && !wr_addr_bad)
      begin
        // While locked every write to this register is ignored, including the lock bit.
        if (!ctl_r[`CT_LK])
        begin
          ctl_r <= (ctl_r & ~`CT_SW_MASK) | (wd & `CT_SW_MASK) | (ctl_r & 32'h00000080);
          if (wd[`CT_LK])
            ctl_r[`CT_LK] <= 1'b1;
          if (!wd[`CT_OPTION_WRITE_ALLOWED])
            ctl_r[`CT_OPTION_WRITE_ALLOWED] <= 1'b0;
          else
            ctl_r[`CT_OPTION_WRITE_ALLOWED] <= ctl_r[`CT_OPTION_WRITE_ALLOWED];
        end
      end
      else if (op_done && !stat_r[`ST_BUSY])
        ctl_r[6] <= 1'b0;
      if (stat_r[`ST_BUSY] && !stat_nxt[`ST_BUSY])
        ctl_r[6] <= 1'b0;
    end
  end

  assign control_locked       = ctl_r[`CT_LK];
  assign option_write_allowed = ctl_r[`CT_OPTION_WRITE_ALLOWED];
  assign control_cmd          = ctl_r[6:0];
  assign done_irq  = ctl_r[`CT_DONE_IRQ_ENABLE] && stat_r[`ST_OP_DONE_FLAG];
  assign error_irq = ctl_r[`CT_ERROR_IRQ_ENABLE] && (|stat_r[4:2]);

  wire ar_fire = s_axi_arvalid && s_axi_arready;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else if (ar_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= addr_ok(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr[4:0])
        `OFS_WAIT_CACHE_CONFIG: s_axi_rdata <= ws_r & `WS_MASK;
        `OFS_OPERATION_STATUS:  s_axi_rdata <= {26'h0, stat_r};
        `OFS_OPERATION_CONTROL: s_axi_rdata <= ctl_r;
        default:                s_axi_rdata <= 32'h00000000;
      endcase
      if (!addr_ok(s_axi_araddr))
        s_axi_rdata <= 32'h00000000;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  flash_read_wait u_read_wait (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .wait_state_count (ws_r[2:0]),
    .rd_req           (flash_rd_req),
    .rd_data_in       (flash_rd_data_in),
    .rd_ack           (flash_rd_ack),
    .rd_data          (flash_rd_data)
  );
endmodule

// [tb/flash_engine_model.sv]
// Flash array side model: runs one erase or program per request and supplies array data.
`timescale 1ns/100ps
module flash_engine_model #(
  parameter [31:0] ARRAY_WORD = 32'h5a5ac3c3
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        go,
  input  wire [1:0]  kind,
  input  wire [7:0]  dly,
  output logic       op_start,
  output wire        op_done,
  output wire        op_protect_err,
  output wire        op_align_err,
  output wire        op_program_err,
  output wire [31:0] flash_rd_data_in
);
  logic [7:0] cnt_r;
  logic [3:0] res_r;
  // Kind 0 ends well, kinds 1 to 3 end in one of the three faults.
  assign {op_program_err, op_align_err, op_protect_err, op_done} = res_r;
  assign flash_rd_data_in = ARRAY_WORD;
  always @(posedge aclk)
  begin
    op_start <= 1'b0;
    res_r <= 4'h0;
    if (!aresetn)
      cnt_r <= 8'h00;
    else if (go)
    begin
      op_start <= 1'b1;
      cnt_r <= dly;
    end
    else if (cnt_r != 8'h00)
    begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01)
        res_r <= 4'h1 << kind;
    end
  end
endmodule

// [tb/flash_ctrl_chk.sv]
// Concurrent checks on the ports of the flash controller register interface.
`timescale 1ns/100ps
module flash_ctrl_chk (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_bvalid,
  input wire       flash_rd_req,
  input wire       flash_rd_ack,
  input wire [2:0] wait_state_count,
  input wire       instr_cache_on,
  input wire       data_cache_on,
  input wire       instr_cache_flush,
  input wire       data_cache_flush,
  input wire       program_width_sel,
  input wire       control_locked,
  input wire       op_done,
  input wire       op_protect_err,
  input wire       op_align_err,
  input wire       op_program_err,
  input wire       done_irq,
  input wire       error_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_two_waits;
    !flash_rd_ack [*2] ##1 flash_rd_ack;
  endsequence
  a_dflush_off:
    assert property (data_cache_flush |-> !$past(data_cache_on)) else $error("data flush while on");
  a_iflush_off:
    assert property (instr_cache_flush |-> !$past(instr_cache_on)) else $error("instr flush while on");
  a_wait_two:
    assert property (flash_rd_req && wait_state_count == 3'h2 |=> s_two_waits)
      else $error("two wait read mistimed");
  a_wait_none:
    assert property (flash_rd_req && wait_state_count == 3'h0 |=> flash_rd_ack)
      else $error("zero wait read late");
  a_reset_vals:
    assert property (!$past(aresetn) |-> control_locked && wait_state_count == 3'h0
      && instr_cache_on && data_cache_on && !program_width_sel) else $error("bad reset values");
  a_width_by_write:
    assert property ($changed(program_width_sel) && $past(aresetn) |-> s_axi_bvalid)
      else $error("width changed without write");
  a_unlock_by_write:
    assert property ($fell(control_locked) && $past(aresetn) |-> s_axi_bvalid)
      else $error("unlock without write");
  a_done_irq_cause:
    assert property ($rose(done_irq) && $past(aresetn) |-> $past(op_done) || s_axi_bvalid)
      else $error("done irq without cause");
  a_err_irq_cause:
    assert property ($rose(error_irq) && $past(aresetn) |-> $past(op_protect_err)
      || $past(op_align_err) || $past(op_program_err) || s_axi_bvalid) else $error("err irq");
endmodule
bind flash_ctrl_register_interface flash_ctrl_chk i_flash_ctrl_chk (.*);

// [tb/testbench.sv]
// Self-checking bench for the flash controller register interface.
`timescale 1ns/100ps
`include "flash_ctrl_map.vh"
module testbench;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [31:0] flash_rd_data_in, flash_rd_data;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, kind;
  logic [2:0]  wait_state_count;
  logic [6:0]  control_cmd;
  logic [7:0]  dly;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, op_start, op_done, op_protect_err, op_align_err, op_program_err;
  logic        flash_rd_req, flash_rd_ack, prefetch_on, instr_cache_on, data_cache_on;
  logic        instr_cache_flush, data_cache_flush, program_width_sel, control_locked;
  logic        option_write_allowed, done_irq, error_irq, go;
  int          n_mismatch, compares, cyc, nfl, k, w;
  flash_ctrl_register_interface i_flash_ctrl_register_interface (.*);
  flash_engine_model i_flash_engine_model (.*);
  task chk(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wr(input [31:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input [31:0] a, input [31:0] exp, input [1:0] er);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask
  task op(input [1:0] kd, input [7:0] d);
    @(posedge aclk);
    {kind, dly, go} <= {kd, d, 1'b1};
    @(posedge aclk);
    go <= 1'b0;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // A hang ends the run through the same closing report.
  always @(posedge aclk)
  begin
    cyc++;
    nfl <= nfl + data_cache_flush + instr_cache_flush;
    if (cyc == 6000)
    begin
      n_mismatch++;
      close_out;
    end
  end
  initial
  begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = 100'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {aresetn, flash_rd_req, go, kind, dly} = 13'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_WAIT_CACHE_CONFIG, `RST_WAIT_CACHE_CONFIG, 2'h0);
    rd(`OFS_OPERATION_CONTROL, `RST_OPERATION_CONTROL, 2'h0);
    rd(`OFS_OPERATION_STATUS, 32'h0, 2'h0);
    rd(`OFS_CONTROL_UNLOCK_KEY, 32'h0, 2'h0);
    rd(32'h14, 32'h0, 2'h2);
    $display("test reset values done");
    wr(`OFS_WAIT_CACHE_CONFIG, 32'h8013, 4'hf, 2'h0);
    chk({program_width_sel, instr_cache_on, data_cache_on, prefetch_on}, 32'h9);
    wr(`OFS_WAIT_CACHE_CONFIG, 32'h1813, 4'hf, 2'h0);
    wr(`OFS_WAIT_CACHE_CONFIG, 32'h0613, 4'hf, 2'h0);
    wr(`OFS_WAIT_CACHE_CONFIG, 32'h1e13, 4'hf, 2'h0);
    chk(nfl, 32'h2);
    wr(`OFS_WAIT_CACHE_CONFIG, 32'h0, 4'h3, 2'h2);
    rd(`OFS_WAIT_CACHE_CONFIG, 32'h0633, 2'h0);
    $display("test cache config done");
    for (k = 0; k < 4; k++)
    begin
      wr(`OFS_WAIT_CACHE_CONFIG, k, 4'hf, 2'h0);
      chk(wait_state_count, k);
      @(posedge aclk);
      flash_rd_req <= 1'b1;
      @(posedge aclk);
      flash_rd_req <= 1'b0;
      w = 0;
      do
      begin
        @(posedge aclk);
        w++;
      end while (!flash_rd_ack && w < 99);
      chk(w, k + 1);
      chk(flash_rd_data, 32'h5a5ac3c3);
    end
    $display("test wait states done");
    wr(`OFS_OPERATION_CONTROL, 32'h1400, 4'hf, 2'h0);
    rd(`OFS_OPERATION_CONTROL, 32'h80, 2'h0);
    wr(`OFS_CONTROL_UNLOCK_KEY, `KEY_WORD1, 4'hf, 2'h0);
    wr(`OFS_CONTROL_UNLOCK_KEY, `KEY_WORD2, 4'hf, 2'h0);
    rd(`OFS_OPERATION_CONTROL, 32'h0, 2'h0);
    wr(`OFS_OPTION_UNLOCK_KEY, `KEY_WORD1, 4'hf, 2'h0);
    wr(`OFS_OPTION_UNLOCK_KEY, `KEY_WORD2, 4'hf, 2'h0);
    rd(`OFS_OPERATION_CONTROL, 32'h200, 2'h0);
    chk(option_write_allowed, 32'h1);
    wr(`OFS_OPERATION_CONTROL, 32'h1400, 4'hf, 2'h0);
    rd(`OFS_OPERATION_CONTROL, 32'h1400, 2'h0);
    $display("test unlock done");
    for (k = 0; k < 4; k++)
    begin
      wr(`OFS_OPERATION_CONTROL, 32'h1441, 4'hf, 2'h0);
      chk(control_cmd, 32'h41);
      op(k[1:0], k == 0 ? 8'h14 : 8'h01);
      if (k == 0) rd(`OFS_OPERATION_STATUS, 32'h1, 2'h0);
      @(posedge aclk iff (op_done | op_protect_err | op_align_err | op_program_err));
      wr(`OFS_OPERATION_STATUS, 32'h0, 4'hf, 2'h0);
      rd(`OFS_OPERATION_STATUS, 32'h20 >> k, 2'h0);
      chk({done_irq, error_irq}, k == 0 ? 32'h2 : 32'h1);
      chk(control_cmd, 32'h01);
      wr(`OFS_OPERATION_STATUS, 32'h20 >> k, 4'hf, 2'h0);
      rd(`OFS_OPERATION_STATUS, 32'h0, 2'h0);
    end
    $display("test status flags done");
    wr(`OFS_OPERATION_CONTROL, 32'h1480, 4'hf, 2'h0);
    chk(control_locked, 32'h1);
    $display("test relock done");
    close_out;
  end
endmodule
